/* File: include/icf_pkg.sv */
package icf_pkg;

  // clock and millisecond base
  localparam int ICF_CLK_NS    = 4;                            // 250 mhz system clock
  localparam int ICF_MS_NS     = 1000000;                      // one millisecond in ns
  localparam int ICF_MS_CYCLES = ICF_MS_NS / ICF_CLK_NS;       // cycles per ms tick

  // capture glitch filter minimum stable times, rounded up to whole cycles
  localparam int ICF_GF1_NS = 111;
  localparam int ICF_GF2_NS = 1780;
  localparam int ICF_GF3_NS = 14220;
  localparam logic [11:0] ICF_GF_CYC [4] = '{
    12'h000,
    12'((ICF_GF1_NS + ICF_CLK_NS - 1) / ICF_CLK_NS),
    12'((ICF_GF2_NS + ICF_CLK_NS - 1) / ICF_CLK_NS),
    12'((ICF_GF3_NS + ICF_CLK_NS - 1) / ICF_CLK_NS)
  };

  // software debounce periods in ms, codes 0 to 7
  localparam logic [9:0] ICF_DEB_MS [8] = '{
    10'h000, 10'h00A, 10'h014, 10'h028, 10'h064, 10'h0C8, 10'h190, 10'h3E8
  };

  // input type codes
  localparam logic [7:0] ICF_TYP_DIS      = 8'h00;  // disabled
  localparam logic [7:0] ICF_TYP_FRQ_LO   = 8'h28;  // first frequency range
  localparam logic [7:0] ICF_TYP_FRQ_HI   = 8'h2A;  // last frequency range
  localparam logic [7:0] ICF_TYP_PWM_LO   = 8'h32;
  localparam logic [7:0] ICF_TYP_PWM_HI   = 8'h33;
  localparam logic [7:0] ICF_TYP_DIG_NRM  = 8'h3C;
  localparam logic [7:0] ICF_TYP_DIG_INV  = 8'h3D;
  localparam logic [7:0] ICF_TYP_DIG_LAT  = 8'h3E;
  localparam logic [7:0] ICF_TYP_CNT_WIN  = 8'h46;
  localparam logic [7:0] ICF_TYP_CNT_RISE = 8'h47;
  localparam logic [7:0] ICF_TYP_CNT_BOTH = 8'h48;

  // pull and filter codes
  localparam logic [1:0] ICF_PULL_UP = 2'h1;
  localparam logic [1:0] ICF_PULL_DN = 2'h2;
  localparam logic [1:0] ICF_FLT_MOV = 2'h1;
  localparam logic [1:0] ICF_FLT_REP = 2'h2;

  // frequency gate and rpm scale
  localparam logic [15:0] ICF_GATE_MS = 16'h03E8;
  localparam logic [15:0] ICF_RPM_MUL = 16'h003C;

  // register byte offsets
  localparam logic [7:0] ICF_OFS_CFG  = 8'h00;
  localparam logic [7:0] ICF_OFS_FILT = 8'h04;
  localparam logic [7:0] ICF_OFS_RNG  = 8'h08;
  localparam logic [7:0] ICF_OFS_WIN  = 8'h0C;
  localparam logic [7:0] ICF_OFS_MAXC = 8'h10;
  localparam logic [7:0] ICF_OFS_VAL  = 8'h14;
  localparam logic [7:0] ICF_OFS_CAPT = 8'h18;

  // field positions
  localparam int ICF_CFG_TYP_LSB  = 0;
  localparam int ICF_CFG_DEB_LSB  = 8;
  localparam int ICF_CFG_GF_LSB   = 12;
  localparam int ICF_CFG_PULL_LSB = 16;
  localparam int ICF_CFG_POL_BIT  = 20;
  localparam int ICF_CFG_PPR_BIT  = 24;
  localparam int ICF_FLT_TYP_LSB  = 0;
  localparam int ICF_FLT_K_LSB    = 16;
  localparam int ICF_RNG_MAX_LSB  = 16;

  // reset values and writable masks
  localparam logic [31:0] ICF_CFG_RST  = 32'h0002_0000;
  localparam logic [31:0] ICF_FILT_RST = 32'h0000_0000;
  localparam logic [31:0] ICF_RNG_RST  = 32'hFFFF_0000;
  localparam logic [31:0] ICF_WIN_RST  = 32'h0000_03E8;
  localparam logic [31:0] ICF_MAXC_RST = 32'h0000_FFFF;
  localparam logic [31:0] ICF_CFG_MSK  = 32'h0113_37FF;
  localparam logic [31:0] ICF_FILT_MSK = 32'hFFFF_0003;
  localparam logic [31:0] ICF_16_MSK   = 32'h0000_FFFF;

  // axi responses
  localparam logic [1:0] ICF_RESP_OK  = 2'h0;
  localparam logic [1:0] ICF_RESP_ERR = 2'h2;

endpackage

/* File: design/icf_input_cond.sv */
// Summary of operation
// - debounce codes 0-7 give 0..1000 ms
// - frequency and pwm types use capture timer
// - glitch filter setting applies to capture channel
// - frequency reports rpm or hertz per option
// - digital types give one-bit on/off state
// - pull none/up/down, pulldown by default
// - polarity high/low active, high default
// - normal reports active level, inverse complements
// - latched reports 1 on inactive-to-active edge
// - no fault flag in digital types
// - counter type counts pulses per window
// - rising-edge counter wraps past maximum count
// - both-edge counter wraps past maximum count
// - counter types only on capable inputs
// - clamp control value to min/max range
// - filter select none, moving, repeating; none default
// - moving average adds difference over constant
// - repeating average outputs sum over N
// - filter settings held per input instance
// - type codes decode disabled/frequency/pwm/digital/counter
module icf_input_cond #(
  parameter int MS_CYCLES   = icf_pkg::ICF_MS_CYCLES,  // shorten for simulation
  parameter bit CNT_CAPABLE = 1'b1                     // input can run counter types
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        pin_in,              // asynchronous input pin level
  input  wire logic        s_axi_awvalid_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_bready_in,
  input  wire logic        s_axi_arvalid_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_rready_in,
  output logic             s_axi_awready_out,
  output logic             s_axi_wready_out,
  output logic             s_axi_bvalid_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_arready_out,
  output logic             s_axi_rvalid_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic [15:0]      value_out,           // filtered, clamped control value
  output logic             state_out,           // digital measured state
  output logic             diag_out,            // out-of-range fault
  output logic             cap_sel_out,         // pin routed to capture timer
  output logic             pull_up_en_out,
  output logic             pull_dn_en_out
);

  localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

  // whole module state
  typedef struct packed {
    logic [31:0] cfg;       // type, debounce, glitch, pull, polarity, rpm option
    logic [31:0] filt;      // filter type and constant
    logic [31:0] rng;       // min and max range
    logic [31:0] win;       // counter window in ms
    logic [31:0] maxc;      // pulse counter maximum
    logic        s1;        // synchroniser first stage
    logic        s2;        // synchroniser second stage
    logic [11:0] gf_cnt;    // glitch filter stability count
    logic        gf_lvl;    // glitch-filtered level
    logic        gf_prev;   // for edge detection
    logic [17:0] deb_cyc;   // debounce cycles within current ms
    logic [9:0]  deb_ms;    // debounce whole ms
    logic        deb_lvl;   // debounced level
    logic [17:0] ms_cyc;    // free ms prescaler
    logic        tick;      // one-cycle ms sample strobe
    logic        act_prev;  // previous active level
    logic        state;
    logic [15:0] cnt;
    logic [15:0] win_ms;
    logic [15:0] win_res;
    logic [15:0] gate_ms;
    logic [15:0] hz_cnt;
    logic [15:0] hz_res;
    logic [15:0] tmr;       // 16-bit capture timer
    logic [15:0] period;
    logic [15:0] high;
    logic [15:0] ctl;       // clamped value of the last sample
    logic [15:0] filt_out;
    logic [31:0] acc;
    logic [15:0] nsamp;
    logic        diag;
    logic        cap_sel;
    logic        pu;
    logic        pd;
    logic        awrdy;
    logic        aw_hv;
    logic [7:0]  aw_adr;
    logic        wrdy;
    logic        w_hv;
    logic [31:0] wdat;
    logic [3:0]  wstb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } icf_state_t;

  icf_state_t q;            // registered state
  icf_state_t d;            // next state

  // configuration fields
  logic [7:0]  typ;
  logic [2:0]  deb_sel;
  logic [1:0]  gf_sel;
  logic [1:0]  pull;
  logic        pol;
  logic        ppr;
  logic [1:0]  ftyp;
  logic [15:0] fk;
  logic [15:0] rmin;
  logic [15:0] rmax;
  assign typ     = q.cfg[icf_pkg::ICF_CFG_TYP_LSB +: 8];
  assign deb_sel = q.cfg[icf_pkg::ICF_CFG_DEB_LSB +: 3];
  assign gf_sel  = q.cfg[icf_pkg::ICF_CFG_GF_LSB +: 2];
  assign pull    = q.cfg[icf_pkg::ICF_CFG_PULL_LSB +: 2];
  assign pol     = q.cfg[icf_pkg::ICF_CFG_POL_BIT];
  assign ppr     = q.cfg[icf_pkg::ICF_CFG_PPR_BIT];
  assign ftyp    = q.filt[icf_pkg::ICF_FLT_TYP_LSB +: 2];
  assign fk      = q.filt[icf_pkg::ICF_FLT_K_LSB +: 16];
  assign rmin    = q.rng[15:0];
  assign rmax    = q.rng[icf_pkg::ICF_RNG_MAX_LSB +: 16];

  // type decode
  logic is_frq, is_pwm, is_dig, is_cnt, is_cap;
  assign is_frq = typ >= icf_pkg::ICF_TYP_FRQ_LO && typ <= icf_pkg::ICF_TYP_FRQ_HI;
  assign is_pwm = typ >= icf_pkg::ICF_TYP_PWM_LO && typ <= icf_pkg::ICF_TYP_PWM_HI;
  assign is_dig = typ >= icf_pkg::ICF_TYP_DIG_NRM && typ <= icf_pkg::ICF_TYP_DIG_LAT;
  // counter codes only decode on capable inputs, otherwise they act as disabled except that diag rises when rmin is above 0
  assign is_cnt = CNT_CAPABLE && typ >= icf_pkg::ICF_TYP_CNT_WIN
                  && typ <= icf_pkg::ICF_TYP_CNT_BOTH;
  assign is_cap = is_frq | is_pwm;

  // helper terms
  logic [11:0] gf_tgt;
  logic [9:0]  deb_tgt;
  logic        act, lat_rise, rise, fall;
  logic [15:0] k16, meas, cl;
  logic [31:0] rpm;
  logic signed [17:0] diff, quo, msum;
  logic [31:0] acc_n;
  assign gf_tgt   = icf_pkg::ICF_GF_CYC[gf_sel];
  assign deb_tgt  = icf_pkg::ICF_DEB_MS[deb_sel];
  assign act      = q.deb_lvl ^ pol;
  assign lat_rise = act & ~q.act_prev;
  assign rise     = q.gf_lvl & ~q.gf_prev;
  assign fall     = ~q.gf_lvl & q.gf_prev;
  assign k16      = (fk == 16'h0000) ? 16'h0001 : fk;  // zero constant acts as one
  assign rpm      = q.hz_res * icf_pkg::ICF_RPM_MUL;

  // raw measurement by type
  always_comb begin
    meas = 16'h0000;
    if (is_frq) begin
      // rpm saturates rather than wrapping in 16 bits
      meas = ppr ? ((rpm[31:16] != 16'h0000) ? 16'hFFFF : rpm[15:0]) : q.hz_res;
    end else if (is_pwm) begin
      meas = q.high;
    end else if (is_dig) begin
      meas = {15'h0000, q.state};
    end else if (is_cnt && typ == icf_pkg::ICF_TYP_CNT_WIN) begin
      meas = q.win_res;
    end else if (is_cnt) begin
      meas = q.cnt;
    end
  end

  // range clamp and filter arithmetic
  always_comb begin
    cl = meas;
    if (meas > rmax) begin
      cl = rmax;
    end else if (meas < rmin) begin
      cl = rmin;
    end
    diff  = $signed({2'b00, cl}) - $signed({2'b00, q.filt_out});
    quo   = diff / $signed({2'b00, k16});
    msum  = $signed({2'b00, q.filt_out}) + quo;
    acc_n = q.acc + {16'h0000, cl};
  end

  // byte-lane merge with reserved bits forced to zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] stb, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r & msk;
  endfunction

  // next-state logic
  always_comb begin
    logic clr;
    logic [31:0] nc, nf;
    clr = 1'b0;
    nc  = q.cfg;
    nf  = q.filt;
    d   = q;
    // input synchroniser
    d.s1 = pin_in;
    d.s2 = q.s1;
    // free-running ms strobe
    d.tick   = (q.ms_cyc == MS_LAST);
    d.ms_cyc = d.tick ? 18'h00000 : q.ms_cyc + 18'h00001;

    // axi write channels are taken independently, in either order
    if (s_axi_awvalid_in && q.awrdy) begin
      d.aw_hv  = 1'b1;
      d.aw_adr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && q.wrdy) begin
      d.w_hv = 1'b1;
      d.wdat = s_axi_wdata_in;
      d.wstb = s_axi_wstrb_in;
    end
    if (q.bvalid && s_axi_bready_in) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_hv && q.w_hv && !q.bvalid) begin
      d.aw_hv  = 1'b0;
      d.w_hv   = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = icf_pkg::ICF_RESP_OK;
      // settings are per instance, so no write touches another input
      unique case (q.aw_adr)
        icf_pkg::ICF_OFS_CFG:  nc = merge(q.cfg, q.wdat, q.wstb, icf_pkg::ICF_CFG_MSK);
        icf_pkg::ICF_OFS_FILT: nf = merge(q.filt, q.wdat, q.wstb, icf_pkg::ICF_FILT_MSK);
        icf_pkg::ICF_OFS_RNG:  d.rng = merge(q.rng, q.wdat, q.wstb, 32'hFFFF_FFFF);
        icf_pkg::ICF_OFS_WIN:  d.win = merge(q.win, q.wdat, q.wstb, icf_pkg::ICF_16_MSK);
        icf_pkg::ICF_OFS_MAXC: d.maxc = merge(q.maxc, q.wdat, q.wstb, icf_pkg::ICF_16_MSK);
        icf_pkg::ICF_OFS_VAL, icf_pkg::ICF_OFS_CAPT: ;  // read-only, write ignored
        default: d.bresp = icf_pkg::ICF_RESP_ERR;      // unmapped
      endcase
      // a type or filter change restarts counter, window, frequency gate, latch and filter state
      clr = (nc[7:0] != typ) || (nf != q.filt);
      d.cfg  = nc;
      d.filt = nf;
    end
    d.awrdy = !d.aw_hv;
    d.wrdy  = !d.w_hv;

    // axi read: one cycle from address to data
    if (q.rvalid && s_axi_rready_in) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp  = icf_pkg::ICF_RESP_OK;
      unique case (s_axi_araddr_in)
        icf_pkg::ICF_OFS_CFG:  d.rdata = q.cfg;
        icf_pkg::ICF_OFS_FILT: d.rdata = q.filt;
        icf_pkg::ICF_OFS_RNG:  d.rdata = q.rng;
        icf_pkg::ICF_OFS_WIN:  d.rdata = q.win;
        icf_pkg::ICF_OFS_MAXC: d.rdata = q.maxc;
        icf_pkg::ICF_OFS_VAL:  d.rdata = {14'h0000, q.diag, q.state, q.filt_out};
        icf_pkg::ICF_OFS_CAPT: d.rdata = {q.high, q.period};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = icf_pkg::ICF_RESP_ERR;
        end
      endcase
    end
    d.arrdy = !d.rvalid;

    // capture glitch filter: level must hold for the selected time
    d.gf_prev = q.gf_lvl;
    if (q.s2 != q.gf_lvl) begin
      if (q.gf_cnt + 12'h001 >= gf_tgt) begin
        d.gf_lvl = q.s2;
        d.gf_cnt = 12'h000;
      end else begin
        d.gf_cnt = q.gf_cnt + 12'h001;
      end
    end else begin
      d.gf_cnt = 12'h000;
    end

    // software debounce: own ms timer restarts on every bounce
    if (q.s2 == q.deb_lvl) begin
      d.deb_cyc = 18'h00000;
      d.deb_ms  = 10'h000;
    end else if (deb_tgt == 10'h000) begin
      d.deb_lvl = q.s2;
    end else if (q.deb_cyc == MS_LAST) begin
      d.deb_cyc = 18'h00000;
      if (q.deb_ms + 10'h001 == deb_tgt) begin
        d.deb_lvl = q.s2;
        d.deb_ms  = 10'h000;
      end else begin
        d.deb_ms = q.deb_ms + 10'h001;
      end
    end else begin
      d.deb_cyc = q.deb_cyc + 18'h00001;
    end

    // digital interpretation
    d.act_prev = act;
    if (typ == icf_pkg::ICF_TYP_DIG_NRM) begin
      d.state = act;
    end else if (typ == icf_pkg::ICF_TYP_DIG_INV) begin
      d.state = ~act;
    end else if (typ == icf_pkg::ICF_TYP_DIG_LAT) begin
      // an edge in the clearing sample wins over the clear
      if (lat_rise) begin
        d.state = 1'b1;
      end else if (q.tick) begin
        d.state = 1'b0;
      end
    end else begin
      d.state = 1'b0;
    end

    // pulse counters
    if (!is_cnt) begin
      d.cnt = 16'h0000;
    end else if (typ == icf_pkg::ICF_TYP_CNT_WIN) begin
      if (rise) begin
        d.cnt = q.cnt + 16'h0001;
      end
      if (q.tick) begin
        d.win_ms = q.win_ms + 16'h0001;
        if (q.win_ms + 16'h0001 >= q.win[15:0]) begin
          d.win_res = d.cnt;
          d.cnt     = 16'h0000;
          d.win_ms  = 16'h0000;
        end
      end
    end else if (rise || (fall && typ == icf_pkg::ICF_TYP_CNT_BOTH)) begin
      d.cnt = (q.cnt >= q.maxc[15:0]) ? 16'h0000 : q.cnt + 16'h0001;
    end

    // frequency gate and capture timer
    if (is_frq) begin
      if (rise) begin
        d.hz_cnt = q.hz_cnt + 16'h0001;
      end
      if (q.tick) begin
        d.gate_ms = q.gate_ms + 16'h0001;
        if (q.gate_ms + 16'h0001 >= icf_pkg::ICF_GATE_MS) begin
          d.hz_res  = d.hz_cnt;
          d.hz_cnt  = 16'h0000;
          d.gate_ms = 16'h0000;
        end
      end
    end
    if (is_cap) begin
      // timer saturates so the first edge after a stalled input captures the longest period
      d.tmr = (q.tmr == 16'hFFFF) ? q.tmr : q.tmr + 16'h0001;
      if (rise) begin
        d.period = q.tmr;
        d.tmr    = 16'h0000;
      end
      if (fall) begin
        d.high = q.tmr;
      end
    end

    // per-sample clamp, diagnostics and filtering
    if (q.tick) begin
      d.ctl  = cl;
      d.diag = (typ != icf_pkg::ICF_TYP_DIS) && !is_dig && (meas < rmin || meas > rmax);
      if (ftyp == icf_pkg::ICF_FLT_MOV) begin
        d.filt_out = msum[15:0];
      end else if (ftyp == icf_pkg::ICF_FLT_REP) begin
        if (q.nsamp + 16'h0001 >= k16) begin
          d.filt_out = 16'(acc_n / {16'h0000, k16});
          d.acc      = 32'h0000_0000;
          d.nsamp    = 16'h0000;
        end else begin
          d.acc   = acc_n;
          d.nsamp = q.nsamp + 16'h0001;
        end
      end else begin
        d.filt_out = cl;
      end
    end
    if (is_dig) begin
      d.diag = 1'b0;
    end

    // pin-facing outputs
    d.cap_sel = is_cap;
    d.pu = (is_cap | is_dig | is_cnt) && pull == icf_pkg::ICF_PULL_UP;
    d.pd = (is_cap | is_dig | is_cnt) && pull == icf_pkg::ICF_PULL_DN;

    if (clr) begin
      d.cnt      = 16'h0000;
      d.win_ms   = 16'h0000;
      d.win_res  = 16'h0000;
      d.state    = 1'b0;
      d.acc      = 32'h0000_0000;
      d.nsamp    = 16'h0000;
      d.filt_out = 16'h0000;
      d.hz_cnt   = 16'h0000;
      d.gate_ms  = 16'h0000;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q      <= '0;
      q.cfg  <= icf_pkg::ICF_CFG_RST;   // pulldown, active high
      q.filt <= icf_pkg::ICF_FILT_RST;  // no filtering
      q.rng  <= icf_pkg::ICF_RNG_RST;
      q.win  <= icf_pkg::ICF_WIN_RST;
      q.maxc <= icf_pkg::ICF_MAXC_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready_out = q.awrdy;
  assign s_axi_wready_out  = q.wrdy;
  assign s_axi_bvalid_out  = q.bvalid;
  assign s_axi_bresp_out   = q.bresp;
  assign s_axi_arready_out = q.arrdy;
  assign s_axi_rvalid_out  = q.rvalid;
  assign s_axi_rdata_out   = q.rdata;
  assign s_axi_rresp_out   = q.rresp;
  assign value_out         = q.filt_out;
  assign state_out         = q.state;
  assign diag_out          = q.diag;
  assign cap_sel_out       = q.cap_sel;
  assign pull_up_en_out    = q.pu;
  assign pull_dn_en_out    = q.pd;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_pull_default: assert property ($past(rst_in) |-> pull == icf_pkg::ICF_PULL_DN)
    else $error("pull selection not pulldown after reset");
  a_deb_zero_pass: assert property (deb_tgt == 10'h000 && q.s2 != q.deb_lvl
    |=> q.deb_lvl == $past(q.s2))
    else $error("zero debounce did not pass level");
  a_deb_full_wait: assert property ($changed(q.deb_lvl) && $past(deb_tgt) != 10'h000
    |-> $past(q.deb_ms) == $past(deb_tgt) - 10'h001 && $past(q.deb_cyc) == MS_LAST)
    else $error("debounced level changed early");
  a_cap_routing: assert property (!$past(rst_in) |-> cap_sel_out == $past(is_cap))
    else $error("capture routing mismatch");
  a_rise_wrap: assert property (typ == icf_pkg::ICF_TYP_CNT_RISE && is_cnt && rise
    && q.cnt == q.maxc[15:0] && !(q.aw_hv && q.w_hv && !q.bvalid) |=> q.cnt == 16'h0000)
    else $error("rising counter did not wrap");
  a_both_count: assert property (typ == icf_pkg::ICF_TYP_CNT_BOTH && is_cnt && fall
    && q.cnt < q.maxc[15:0] && !(q.aw_hv && q.w_hv && !q.bvalid)
    |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("falling edge not counted");
  a_no_dig_diag: assert property (is_dig && $past(is_dig) |-> !diag_out)
    else $error("fault raised in digital type");
  a_clamp_range: assert property ($past(q.tick) && rmin <= rmax && $stable(q.rng)
    |-> q.ctl >= rmin && q.ctl <= rmax)
    else $error("control value outside range");
  // an incapable input never decodes a counter type, so this covers it as well
  a_cnt_capable: assert property (!is_cnt |=> q.cnt == 16'h0000)
    else $error("counter ran outside a counter type");
  a_latch_cause: assert property ($rose(q.state)
    && $past(typ) == icf_pkg::ICF_TYP_DIG_LAT |-> $past(lat_rise))
    else $error("latched state set without active edge");
  a_bvalid_hold: assert property (q.bvalid && !s_axi_bready_in |=> q.bvalid)
    else $error("write response dropped");

endmodule

/* File: sim/icf_pin_model.sv */
// sensor or switch on the input pin, with the pull network of the block
module icf_pin_model (
  input  wire logic sys_clk_in,
  input  wire logic drv_en_in,      // sensor actively drives the pin
  input  wire logic drv_val_in,     // level driven by the sensor
  input  wire logic pull_up_en_in,
  input  wire logic pull_dn_en_in,
  output logic      pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_q = 1'b0;  // floating pin wanders so an open input never looks settled
  // free-running toggle for the undriven, unpulled case
  always_ff @(posedge sys_clk_in) begin
    flip_q <= ~flip_q;
  end
  // wire level from sensor drive, then pull resistors
  always_comb begin
    if (drv_en_in) pin_out = drv_val_in;
    else if (pull_up_en_in) pin_out = 1'b1;
    else if (pull_dn_en_in) pin_out = 1'b0;
    else pin_out = flip_q;
  end
endmodule

/* File: sim/icf_input_cond_bench.sv */
module icf_input_cond_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;  // short ms tick keeps the run brief
  logic clk = 1'b0, rst = 1'b1, pin, de = 1'b0, dv = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rd, rdat;
  logic [1:0] rs, br, rr;
  logic awr, wr, bv, arr, rv, st, dg, cs, pu, pd, seen;
  logic [15:0] val;
  int failures = 0, cmp_count = 0, cyc = 0;
  always #2 clk = ~clk;  // 250 mhz
  icf_input_cond #(.MS_CYCLES(MS), .CNT_CAPABLE(1'b1)) i_icf_input_cond (
    .sys_clk_in(clk), .rst_in(rst), .pin_in(pin),
    .s_axi_awvalid_in(awv), .s_axi_awaddr_in(aw), .s_axi_wvalid_in(wv),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_bready_in(bre),
    .s_axi_arvalid_in(arv), .s_axi_araddr_in(ar), .s_axi_rready_in(rre),
    .s_axi_awready_out(awr), .s_axi_wready_out(wr), .s_axi_bvalid_out(bv),
    .s_axi_bresp_out(br), .s_axi_arready_out(arr), .s_axi_rvalid_out(rv),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .value_out(val),
    .state_out(st), .diag_out(dg), .cap_sel_out(cs),
    .pull_up_en_out(pu), .pull_dn_en_out(pd));
  icf_pin_model i_icf_pin_model (.sys_clk_in(clk), .drv_en_in(de), .drv_val_in(dv),
    .pull_up_en_in(pu), .pull_dn_en_in(pd), .pin_out(pin));
  // verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  // each channel is held until its ready is seen at a rising edge, then released
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wr));
    do @(posedge clk); while (!bv);
    rs = br;
    bre <= 1'b0;
  endtask
  // response is taken at the same rising edge that sees rvalid
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rd = rdat;
    rs = rr;
    rre <= 1'b0;
  endtask
  // settle n cycles, then look at outputs away from the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic set_pin(input logic e, input logic v);
    @(posedge clk);
    de <= e;
    dv <= v;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(icf_pkg::ICF_OFS_CFG);
    chk(rd, 32'h0002_0000);
    rd_reg(icf_pkg::ICF_OFS_FILT);
    chk(rd, 32'h0000_0000);
    rd_reg(8'h40);
    chk(rs, 2'h2);
    wr_reg(8'h40, 32'h0000_0000);
    chk(rs, 2'h2);
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0002_003C);
    chk(rs, 2'h0);
    wt(10);
    chk(pd, 1'b1);
    chk(st, 1'b0);
    set_pin(1'b1, 1'b1);
    wt(10);
    chk(st, 1'b1);
    chk(dg, 1'b0);
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0002_003D);
    wt(10);
    chk(st, 1'b0);
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0012_003C);
    wt(10);
    chk(st, 1'b0);
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0002_0028);
    wt(4);
    chk(cs, 1'b1);
    set_pin(1'b1, 1'b0);
    wr_reg(icf_pkg::ICF_OFS_MAXC, 32'h0000_0002);
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0002_0047);
    // two full pulses reach the maximum, a third wraps the count
    for (int i = 0; i < 3; i++) begin
      set_pin(1'b1, 1'b1);
      wt(6);
      set_pin(1'b1, 1'b0);
      wt(6 + 3 * MS);
      chk(val, (i == 2) ? 32'h0 : i + 1);
    end
    // glitch code 1: a short pulse is dropped, a long one counts
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0002_1047);
    set_pin(1'b1, 1'b1);
    wt(10);
    set_pin(1'b1, 1'b0);
    wt(10);
    set_pin(1'b1, 1'b1);
    wt(40);
    set_pin(1'b1, 1'b0);
    wt(40 + 2 * MS);
    chk(val, 32'h1);
    // both edges count, the third edge wraps past maximum 2
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0002_0048);
    set_pin(1'b1, 1'b1);
    wt(6);
    set_pin(1'b1, 1'b0);
    wt(6 + 3 * MS);
    chk(val, 32'h2);
    set_pin(1'b1, 1'b1);
    wt(6 + 3 * MS);
    chk(val, 32'h0);
    // digital state 1 clamped up to minimum 4
    wr_reg(icf_pkg::ICF_OFS_RNG, 32'h0010_0004);
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0002_003C);
    wt(3 * MS);
    chk(val, 32'h4);
    // moving average, constant 2, settles at 3 from 0
    wr_reg(icf_pkg::ICF_OFS_FILT, 32'h0002_0001);
    wt(6 * MS);
    chk(val, 32'h3);
    // repeating average, constant 3: nothing before the third sample
    wr_reg(icf_pkg::ICF_OFS_FILT, 32'h0003_0002);
    wt(MS + 5);
    chk(val, 32'h0);
    wt(2 * MS);
    chk(val, 32'h4);
    // latched: falling edge gives 0, rising edge gives 1 until next sample
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0002_003E);
    set_pin(1'b1, 1'b0);
    wt(10);
    chk(st, 1'b0);
    set_pin(1'b1, 1'b1);
    seen = 1'b0;
    repeat (10) begin
      @(negedge clk);
      seen = seen | st;
    end
    chk(seen, 1'b1);
    wt(2 * MS);
    chk(st, 1'b0);
    // pull-up with a 10 ms debounce
    wr_reg(icf_pkg::ICF_OFS_CFG, 32'h0001_013C);
    wt(4);
    chk(pu, 1'b1);
    set_pin(1'b1, 1'b0);
    wt(5 * MS);
    chk(st, 1'b1);
    wt(6 * MS);
    chk(st, 1'b0);
    complete_run;
  end
endmodule
